/* File: pkg/tos_pkg.sv */
// Constants, register map and encodings of the trigger output sequencer.
package tos_pkg;
  localparam int NUM_UNITS = 2;
  localparam int NUM_GPIO = 7;
  localparam int NUM_CFG = 8;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] UNIT1_BASE = 11'h220;
  localparam logic [ADDR_W-1:0] UNIT2_BASE = 11'h240;
  localparam logic [ADDR_W-1:0] UNIT1_CYCLE_OR_BIT_COUNT_OFS = 11'h230;
  localparam logic [ADDR_W-1:0] UNIT1_PATTERN_OR_ITERATION_COUNT_OFS = 11'h232;
  localparam logic [ADDR_W-1:0] UNIT1_ITERATION_TIME_LOW_OFS = 11'h234;
  localparam logic [ADDR_W-1:0] UNIT1_ITERATION_TIME_HIGH_OFS = 11'h236;
  localparam logic [4:0] CFG_FIRST_OFS = 5'h08;
  localparam logic [4:0] CFG_LAST_OFS = 5'h17;
  localparam int CFG1_IDX = 0;
  localparam int CFG2_IDX = 1;
  localparam int CFG3_IDX = 2;
  localparam int CFG4_IDX = 3;
  localparam int CFG5_IDX = 4;
  localparam int CFG6_IDX = 5;
  localparam int CFG7_IDX = 6;
  localparam int CFG8_IDX = 7;
  localparam logic [DATA_W-1:0] CFG_RESET = 16'h0000;
  localparam int GPIO_SEL_LSB = 0;
  localparam int GPIO_SEL_W = 4;
  localparam int EDGE_SEL_BIT = 7;
  localparam int EDGE_PIN = 1;
  localparam logic [DATA_W-1:0] UNIT1_CFG1_MASK = 16'h000F;
  localparam logic [DATA_W-1:0] UNIT2_CFG1_MASK = 16'h008F;
  localparam int CLK_MHZ = 25;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;
  localparam int PULSE_UNIT_NS = 8;
  localparam int PULSE_SHIFT = $clog2(PULSE_UNIT_NS);
  localparam int ITER_TIME_UNIT_NS = 1;
  localparam logic [1:0] MODE_NEG_CYCLE = 2'h0;
  localparam logic [1:0] MODE_POS_CYCLE = 2'h1;
  localparam logic [1:0] MODE_PATTERN = 2'h2;
  localparam logic [1:0] MODE_OFF = 2'h3;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_WAIT} tos_state_t;
endpackage

/* File: src/tos_pin_or.sv */
// Pin combiner that merges unit outputs onto the GPIO pins.
`timescale 1ns/1ps
`default_nettype none
module tos_pin_or (
  input wire logic [tos_pkg::NUM_UNITS-1:0] unitWave,
  input wire logic [tos_pkg::NUM_UNITS*tos_pkg::GPIO_SEL_W-1:0] unitSel,
  output logic [tos_pkg::NUM_GPIO-1:0] pinLevel
);
  import tos_pkg::*;
  always_comb begin
    pinLevel = '0;
    for (int u = 0; u < NUM_UNITS; u++) begin
      for (int p = 0; p < NUM_GPIO; p++) begin
        // Select codes above the last pin drive nothing.
        if (unitSel[u*GPIO_SEL_W +: GPIO_SEL_W] == GPIO_SEL_W'(p)) begin
          pinLevel[p] = pinLevel[p] | unitWave[u];
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: src/tos_wave_unit.sv */
// Waveform and cascade sequencing engine of one trigger output unit.
`timescale 1ns/1ps
`default_nettype none
module tos_wave_unit (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic startPulse,
  input wire logic [1:0] modeSel,
  input wire logic cascadeEn,
  input wire logic isTail,
  input wire logic [15:0] pulseWidth,
  input wire logic [31:0] cycleWidth,
  input wire logic [15:0] countLimit,
  input wire logic [15:0] patternIter,
  input wire logic [31:0] iterTime,
  input wire logic [31:0] targetTime,
  output logic waveOut,
  output logic busy,
  output logic [31:0] nextTarget,
  output logic nextTargetLoad
);
  import tos_pkg::*;
  tos_state_t state_ff;
  tos_state_t nxt_state;
  logic [32:0] elapsed_ff;
  logic [15:0] cycleCnt_ff;
  logic [15:0] iterCnt_ff;
  logic [3:0] bitIdx_ff;
  logic [31:0] nextTarget_ff;
  logic loadPulse_ff;
  logic wave_ff;
  wire logic [32:0] stepElapsed = elapsed_ff + 33'(CLK_PERIOD_NS);
  wire logic periodEnd = stepElapsed >= {1'b0, cycleWidth};
  wire logic [32:0] restElapsed = stepElapsed - {1'b0, cycleWidth};
  wire logic [32:0] pulseNs = 33'({pulseWidth, PULSE_SHIFT'(0)});
  wire logic isPattern = modeSel == MODE_PATTERN;
  wire logic countDone = (countLimit != 16'h0000) && (cycleCnt_ff + 16'h0001 == countLimit);
  wire logic iterLimitHit = isTail && !isPattern && (iterCnt_ff == patternIter);
  wire logic iterAgain = cascadeEn && !iterLimitHit;
  wire logic runEnd = (state_ff == ST_RUN) && periodEnd && countDone;
  wire logic startOk = startPulse && (modeSel != MODE_OFF) && (state_ff != ST_RUN);
  wire logic pulseHigh = elapsed_ff < pulseNs;
  logic waveLevel;
  always_comb begin
    case (modeSel)
      MODE_POS_CYCLE: waveLevel = pulseHigh;
      MODE_NEG_CYCLE: waveLevel = !pulseHigh;
      MODE_PATTERN: waveLevel = patternIter[bitIdx_ff];
      default: waveLevel = 1'b0;
    endcase
  end
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE, ST_WAIT: begin
        if (startOk) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (modeSel == MODE_OFF) begin
          nxt_state = ST_IDLE;
        end else if (runEnd) begin
          nxt_state = iterAgain ? ST_WAIT : ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      wave_ff <= 1'b0;
      loadPulse_ff <= 1'b0;
      nextTarget_ff <= 32'h0000_0000;
    end else begin
      state_ff <= nxt_state;
      // The final clock of the last cycle keeps its level, so a negative cycle ends high.
      wave_ff <= (state_ff == ST_RUN) && waveLevel;
      loadPulse_ff <= runEnd && iterAgain;
      if (runEnd && iterAgain) begin
        nextTarget_ff <= targetTime + iterTime;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      elapsed_ff <= 33'h0_0000_0000;
      cycleCnt_ff <= 16'h0000;
      bitIdx_ff <= 4'h0;
    end else if (startOk || state_ff != ST_RUN) begin
      elapsed_ff <= 33'h0_0000_0000;
      cycleCnt_ff <= 16'h0000;
      bitIdx_ff <= 4'h0;
    end else if (periodEnd) begin
      // Keeping the remainder stops rounding to the clock period from drifting.
      elapsed_ff <= restElapsed;
      cycleCnt_ff <= cycleCnt_ff + 16'h0001;
      bitIdx_ff <= bitIdx_ff + 4'h1;
    end else begin
      elapsed_ff <= stepElapsed;
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      iterCnt_ff <= 16'h0000;
    end else if (startOk && state_ff == ST_IDLE) begin
      iterCnt_ff <= 16'h0000;
    end else if (runEnd) begin
      iterCnt_ff <= iterAgain ? iterCnt_ff + 16'h0001 : 16'h0000;
    end
  end
  assign waveOut = wave_ff;
  assign busy = state_ff != ST_IDLE;
  assign nextTarget = nextTarget_ff;
  assign nextTargetLoad = loadPulse_ff;
endmodule
`default_nettype wire

/* File: src/tos_sequencer.sv */
// Top of the trigger output sequencer: register file, two units and pin drive.
`timescale 1ns/1ps
`default_nettype none
module tos_sequencer (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [tos_pkg::ADDR_W-1:0] regAddr,
  input wire logic [tos_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [tos_pkg::DATA_W-1:0] regRdData,
  output logic regRdValid,
  input wire logic [tos_pkg::NUM_UNITS-1:0] unitStart,
  input wire logic [tos_pkg::NUM_UNITS*2-1:0] unitMode,
  input wire logic [tos_pkg::NUM_UNITS-1:0] unitCascade,
  input wire logic [tos_pkg::NUM_UNITS-1:0] unitTail,
  input wire logic [tos_pkg::NUM_UNITS*32-1:0] unitTarget,
  output logic [tos_pkg::NUM_UNITS*32-1:0] unitNextTarget,
  output logic [tos_pkg::NUM_UNITS-1:0] unitNextTargetLoad,
  output logic [tos_pkg::NUM_UNITS-1:0] unitBusy,
  output logic [tos_pkg::NUM_GPIO-1:0] gpioOut,
  output logic gpioEdgeLate
);
  import tos_pkg::*;
  logic [DATA_W-1:0] cfg_ff [NUM_UNITS][NUM_CFG];
  logic [DATA_W-1:0] rdData_ff;
  logic rdValid_ff;
  logic [NUM_GPIO-1:0] gpio_ff;
  logic lateEdge_ff;
  logic [NUM_UNITS-1:0] busy_ff;
  wire logic [NUM_UNITS-1:0] unitHit;
  wire logic [4:0] unitOfs = regAddr[4:0];
  wire logic cfgHit = (unitOfs >= CFG_FIRST_OFS) && (unitOfs <= CFG_LAST_OFS) && !regAddr[0];
  wire logic [2:0] cfgIdx = 3'((unitOfs - CFG_FIRST_OFS) >> 1);
  assign unitHit[0] = regAddr[ADDR_W-1:5] == UNIT1_BASE[ADDR_W-1:5];
  assign unitHit[1] = regAddr[ADDR_W-1:5] == UNIT2_BASE[ADDR_W-1:5];
  wire logic [NUM_UNITS-1:0] unitWave;
  wire logic [NUM_UNITS*GPIO_SEL_W-1:0] unitSel;
  wire logic [NUM_UNITS-1:0] unitBusyRaw;
  wire logic [NUM_UNITS-1:0] earlyWave;
  wire logic edgeSelLate = cfg_ff[1][CFG1_IDX][EDGE_SEL_BIT];
  wire logic unit2OnEdgePin = unitSel[GPIO_SEL_W +: GPIO_SEL_W] == GPIO_SEL_W'(EDGE_PIN);
  wire logic moveUnit2 = edgeSelLate && unit2OnEdgePin;
  wire logic [NUM_GPIO-1:0] pinLevel;
  genvar gu;
  generate
    for (gu = 0; gu < NUM_UNITS; gu++) begin : g_unit
      wire logic [DATA_W-1:0] wrMask = (gu == 1) ? UNIT2_CFG1_MASK : UNIT1_CFG1_MASK;
      wire logic wrHere = regWrEn && unitHit[gu] && cfgHit;
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          for (int r = 0; r < NUM_CFG; r++) begin
            cfg_ff[gu][r] <= CFG_RESET;
          end
        end else if (wrHere) begin
          // Only unit two keeps the launch edge bit; elsewhere it stays zero.
          if (cfgIdx == 3'(CFG1_IDX)) begin
            cfg_ff[gu][CFG1_IDX] <= regWrData & wrMask;
          end else begin
            cfg_ff[gu][cfgIdx] <= regWrData;
          end
        end
      end
      assign unitSel[gu*GPIO_SEL_W +: GPIO_SEL_W] =
        cfg_ff[gu][CFG1_IDX][GPIO_SEL_LSB +: GPIO_SEL_W];
      tos_wave_unit u_wave (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .startPulse(unitStart[gu]),
        .modeSel(unitMode[gu*2 +: 2]),
        .cascadeEn(unitCascade[gu]),
        .isTail(unitTail[gu]),
        .pulseWidth(cfg_ff[gu][CFG2_IDX]),
        .cycleWidth({cfg_ff[gu][CFG4_IDX], cfg_ff[gu][CFG3_IDX]}),
        .countLimit(cfg_ff[gu][CFG5_IDX]),
        .patternIter(cfg_ff[gu][CFG6_IDX]),
        .iterTime({cfg_ff[gu][CFG8_IDX], cfg_ff[gu][CFG7_IDX]}),
        .targetTime(unitTarget[gu*32 +: 32]),
        .waveOut(unitWave[gu]),
        .busy(unitBusyRaw[gu]),
        .nextTarget(unitNextTarget[gu*32 +: 32]),
        .nextTargetLoad(unitNextTargetLoad[gu])
      );
    end
  endgenerate
  // When unit two launches on the falling edge its share of pin one leaves the rising path.
  assign earlyWave = {unitWave[1] & !moveUnit2, unitWave[0]};
  tos_pin_or u_pin_or (
    .unitWave(earlyWave),
    .unitSel(unitSel),
    .pinLevel(pinLevel)
  );
  wire logic [DATA_W-1:0] cfgRead = cfg_ff[unitHit[1] ? 1 : 0][cfgIdx];
  // Target time words and the reserved tail of each unit window read as zero.
  wire logic [DATA_W-1:0] rdSel = (cfgHit && |unitHit) ? cfgRead : CFG_RESET;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rdData_ff <= CFG_RESET;
      rdValid_ff <= 1'b0;
    end else begin
      rdValid_ff <= regRdEn;
      if (regRdEn) begin
        rdData_ff <= rdSel;
      end
    end
  end
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gpio_ff <= '0;
      busy_ff <= '0;
    end else begin
      gpio_ff <= pinLevel;
      busy_ff <= unitBusyRaw;
    end
  end
  // Half a period earlier than the rising path; the pad logic ORs it into pin one.
  always_ff @(negedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lateEdge_ff <= 1'b0;
    end else begin
      lateEdge_ff <= moveUnit2 && unitWave[1];
    end
  end
  assign regRdData = rdData_ff;
  assign regRdValid = rdValid_ff;
  assign unitBusy = busy_ff;
  assign gpioOut = gpio_ff;
  assign gpioEdgeLate = lateEdge_ff;
endmodule
`default_nettype wire

/* File: tb/tos_sequencer_chk.sv */
// Port timing checker of the trigger output sequencer.
`timescale 1ns/1ps
`default_nettype none
module tos_sequencer_chk (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [tos_pkg::ADDR_W-1:0] regAddr,
  input wire logic regRdEn,
  input wire logic [tos_pkg::DATA_W-1:0] regRdData,
  input wire logic regRdValid,
  input wire logic [tos_pkg::NUM_UNITS-1:0] unitStart,
  input wire logic [tos_pkg::NUM_UNITS*2-1:0] unitMode,
  input wire logic [tos_pkg::NUM_UNITS*32-1:0] unitNextTarget,
  input wire logic [tos_pkg::NUM_UNITS-1:0] unitNextTargetLoad,
  input wire logic [tos_pkg::NUM_UNITS-1:0] unitBusy
);
  import tos_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  rd_answer_a: assert property (regRdEn |=> regRdValid)
    else $error("read strobe not answered");
  rd_single_a: assert property (!regRdEn |=> !regRdValid)
    else $error("read valid without strobe");
  rd_hold_a: assert property (!regRdEn |=> $stable(regRdData))
    else $error("read data moved without a read");
  rsvd_zero_a: assert property (
    regRdEn && regAddr >= 11'h238 && regAddr <= 11'h23F |=> regRdData == 16'h0000)
    else $error("reserved address read nonzero");
  gap_zero_a: assert property (
    regRdEn && regAddr >= 11'h258 && regAddr <= 11'h25F |=> regRdData == 16'h0000)
    else $error("unit two gap read nonzero");
  odd_zero_a: assert property (regRdEn && regAddr[0] |=> regRdData == 16'h0000)
    else $error("odd address read nonzero");
  load_pulse_a: assert property (unitNextTargetLoad[0] |=> !unitNextTargetLoad[0])
    else $error("next target load longer than one cycle");
  tgt_change_a: assert property ($changed(unitNextTarget[31:0]) |-> unitNextTargetLoad[0])
    else $error("next target changed without load");
  busy_start_a: assert property (
    unitStart[0] && !unitBusy[0] && unitMode[1:0] != MODE_OFF |-> ##[1:2] unitBusy[0])
    else $error("unit did not start");
endmodule
bind tos_sequencer tos_sequencer_chk chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .regAddr(regAddr), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
  .unitStart(unitStart), .unitMode(unitMode), .unitNextTarget(unitNextTarget),
  .unitNextTargetLoad(unitNextTargetLoad), .unitBusy(unitBusy));
`default_nettype wire

/* File: tb/tos_sequencer_tb.sv */
// Self-checking testbench of the trigger output sequencer.
`timescale 1ns/1ps
`default_nettype none
module tos_sequencer_tb;
  import tos_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [DATA_W-1:0] regRdData;
  logic regRdValid;
  logic [1:0] unitStart = '0;
  logic [3:0] unitMode = 4'hF;
  logic [1:0] unitCascade = '0;
  logic [1:0] unitTail = '0;
  logic [63:0] unitTarget = {32'h0000_2000, 32'h1000_0000};
  logic [63:0] unitNextTarget;
  logic [1:0] unitNextTargetLoad;
  logic [1:0] unitBusy;
  logic [NUM_GPIO-1:0] gpioOut;
  logic gpioEdgeLate;
  int error_cnt = 0;
  int checked = 0;
  always #20 clk_sys = ~clk_sys;
  tos_sequencer dut (.clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .regRdValid(regRdValid), .unitStart(unitStart), .unitMode(unitMode),
    .unitCascade(unitCascade), .unitTail(unitTail), .unitTarget(unitTarget),
    .unitNextTarget(unitNextTarget), .unitNextTargetLoad(unitNextTargetLoad),
    .unitBusy(unitBusy), .gpioOut(gpioOut), .gpioEdgeLate(gpioEdgeLate));
  task tick;
    @(posedge clk_sys);
    #1;
  endtask
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // The leading tick keeps a strobe from being lowered and raised in one time step.
  task wr(input logic [10:0] a, input logic [15:0] d);
    tick;
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    tick;
    regWrEn = 1'b0;
  endtask
  task rd(input logic [10:0] a, input logic [15:0] e);
    tick;
    regAddr = a;
    regRdEn = 1'b1;
    tick;
    regRdEn = 1'b0;
    chk("regRdValid", {31'h0, regRdValid}, 32'h1);
    chk("regRdData", {16'h0, regRdData}, {16'h0, e});
  endtask
  task st(input int u);
    tick;
    unitStart[u] = 1'b1;
    tick;
    unitStart[u] = 1'b0;
  endtask
  task wave(input logic [7:0] e);
    for (int k = 0; k < 8; k++) begin
      tick;
      chk("gpioOut2", {31'h0, gpioOut[2]}, {31'h0, e[k]});
    end
  endtask
  task iter(input int expLoad);
    int n;
    n = 0;
    st(0);
    repeat (8) begin
      tick;
      if (unitNextTargetLoad[0] === 1'b1) begin
        n++;
        chk("unitNextTarget", unitNextTarget[31:0], unitTarget[31:0] + 32'h0001_0005);
      end
    end
    chk("loadCount", n, expLoad);
  endtask
  task t_regs;
    for (int i = 0; i < 8; i++) begin
      rd(UNIT1_BASE + 11'(8 + 2 * i), 16'h0000);
      rd(UNIT2_BASE + 11'(8 + 2 * i), 16'h0000);
    end
    for (int i = 4; i < 8; i++) begin
      wr(UNIT1_BASE + 11'(8 + 2 * i), 16'h1230 + 16'(i));
      wr(UNIT2_BASE + 11'(8 + 2 * i), 16'h4560 + 16'(i));
      rd(UNIT1_BASE + 11'(8 + 2 * i), 16'h1230 + 16'(i));
      rd(UNIT2_BASE + 11'(8 + 2 * i), 16'h4560 + 16'(i));
    end
    wr(11'h228, 16'hFFFF);
    wr(11'h248, 16'hFFFF);
    rd(11'h228, 16'h000F);
    rd(11'h248, 16'h008F);
    wr(11'h238, 16'hFFFF);
    rd(11'h238, 16'h0000);
    rd(11'h23E, 16'h0000);
    rd(11'h258, 16'h0000);
    rd(11'h231, 16'h0000);
  endtask
  task t_wave;
    wr(11'h228, 16'h0002);
    wr(11'h248, 16'h0000);
    wr(11'h22A, 16'h000A);
    wr(11'h22C, 16'h0078);
    wr(11'h22E, 16'h0000);
    wr(11'h230, 16'h0002);
    unitMode = {MODE_OFF, MODE_POS_CYCLE};
    st(0);
    wave(8'b0011_0110);
    unitMode = {MODE_OFF, MODE_NEG_CYCLE};
    st(0);
    wave(8'b0100_1000);
    unitMode = {MODE_OFF, MODE_PATTERN};
    wr(11'h22C, 16'h0028);
    wr(11'h230, 16'h0005);
    wr(11'h232, 16'h000D);
    st(0);
    wave(8'b0001_1010);
  endtask
  task t_forever;
    int k;
    wr(11'h230, 16'h0000);
    unitMode = {MODE_OFF, MODE_POS_CYCLE};
    st(0);
    repeat (30) tick;
    chk("unitBusy", {31'h0, unitBusy[0]}, 32'h1);
    unitMode = {MODE_OFF, MODE_OFF};
    k = 0;
    while (unitBusy[0] !== 1'b0) begin
      tick;
      k++;
      if (k > 10) begin
        chk("stopTimeout", 32'h1, 32'h0);
        report_and_stop;
      end
    end
  endtask
  task t_cascade;
    wr(11'h22C, 16'h0050);
    wr(11'h230, 16'h0001);
    wr(11'h232, 16'h0001);
    wr(11'h234, 16'h0005);
    wr(11'h236, 16'h0001);
    unitMode = {MODE_OFF, MODE_POS_CYCLE};
    unitCascade = 2'b01;
    unitTail = 2'b01;
    iter(1);
    iter(0);
    unitTail = 2'b00;
    repeat (3) iter(1);
    unitCascade = 2'b00;
  endtask
  task t_unit2;
    unitMode = {MODE_POS_CYCLE, MODE_OFF};
    wr(11'h248, 16'h0081);
    wr(11'h24A, 16'h000A);
    wr(11'h24C, 16'h0078);
    wr(11'h250, 16'h0001);
    st(1);
    repeat (3) tick;
    chk("gpioEdgeLate", {31'h0, gpioEdgeLate}, 32'h1);
    chk("gpioOut1", {31'h0, gpioOut[1]}, 32'h0);
    repeat (6) tick;
    wr(11'h248, 16'h0002);
    unitMode = {MODE_POS_CYCLE, MODE_POS_CYCLE};
    st(1);
    st(0);
    tick;
    chk("gpioOut2", {31'h0, gpioOut[2]}, 32'h1);
    tick;
    tick;
    chk("gpioOut2", {31'h0, gpioOut[2]}, 32'h1);
    tick;
    chk("gpioOut2", {31'h0, gpioOut[2]}, 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    t_regs;
    t_wave;
    t_forever;
    t_cascade;
    t_unit2;
    report_and_stop;
  end
endmodule
`default_nettype wire
